// ### src/edc_regs.svh
// register offsets, fields and reset values of the dma channels
// assumes apb byte addressing, one aligned word per register
`ifndef EDC_REGS_SVH
`define EDC_REGS_SVH
`define EDC_OFS_STATUS  8'h00
`define EDC_OFS_PEEK    8'h04
`define EDC_OFS_TX_ADDR 8'h08
`define EDC_OFS_TX_LEN  8'h0c
`define EDC_OFS_RX_ADDR 8'h10
`define EDC_OFS_RX_LEN  8'h14
`define EDC_ROM_BASE    8'h80
`define EDC_CTRL_ORDER  7
`define EDC_CTRL_LINE   6
`define EDC_CTRL_TXON   5
`define EDC_CTRL_RXON   4
`define EDC_INT_TX      3
`define EDC_INT_RX      2
`define EDC_CTRL_RST    4'h0
`define EDC_STAT_TAG    4'h0
`define EDC_HDR_WORDS   30'h4
`define EDC_STAT_COPIES 2'h3
`endif

// ### src/edc_pkg.sv
// types shared by the dma channels and the far-side model
package edc_pkg;
  typedef struct packed {
    logic        valid;
    logic [29:0] addr;
    logic [31:0] data;
  } edc_wr_t;
  typedef struct packed {
    logic        valid;
    logic [29:0] addr;
  } edc_rd_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_READ = 4'b0010,
    TX_PUSH = 4'b0100, TX_DONE = 4'b1000
  } edc_tx_st_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_LOAD = 4'b0010,
    RX_FILL = 4'b0100, RX_STAT = 4'b1000
  } edc_rx_st_t;
endpackage

// ### src/edc_ring_mem.sv
// descriptor ring storage, one write port, registered read
// assumes the caller keeps pointers in range
`timescale 1ns/1ps
module edc_ring_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 42
) (
  input  wire logic          sys_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // edc_ring_mem

// ### src/edc_station_rom.sv
// 32-byte station address rom, registered read
// assumes address and checksum come in as parameters
`timescale 1ns/1ps
module edc_station_rom #(
  parameter logic [47:0] STATION = 48'h02_00_00_00_00_01,
  parameter logic [15:0] CHKSUM  = 16'h0000
) (
  input  wire logic       sys_clk_i,
  input  wire logic [4:0] addr_i,
  output logic      [7:0] data_o
);
  logic [63:0]  fwd;
  logic [63:0]  rev;
  logic [255:0] image;
  logic [7:0]   bytes [32];
  assign fwd = {STATION, CHKSUM};
  // fwd, reversed, copy, test pattern; byte 0 in top lane
  assign rev   = {<<8{fwd}};
  assign image = {fwd, rev, fwd, 64'hff_00_55_aa_ff_00_55_aa};
  for (genvar i = 0; i < 32; i++) begin : g_byte
    assign bytes[i] = image[255-8*i -: 8];
  end
  always_ff @(posedge sys_clk_i) begin
    data_o <= bytes[addr_i];
  end
endmodule // edc_station_rom

// ### src/edc_dma.sv
// two dma channels between a network controller and memory
// assumes apb master, word-wide memory ports, sync inputs
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "edc_regs.svh"
// Notes on behaviour
// - send address word-aligned, first two bytes skipped
// - send length is 16-bit byte count
// - command AND status nonzero stops send, flags
// - send disable stops reads, no flag; reset clears
// - per packet: store status, flag, next descriptor
// - receive address aligned, four status copies, skip
// - status word field layout top to bottom
// - receive length twelve bits from bits 15-4
// - unused quadwords reported, all ones on overflow
// - receive command AND status stops, stores, flags
// - unmatched or bad packets flushed, buffer reused
// - selected error kinds consume buffer, flag
// - sixteen-entry ring, empty equal, full plus one
// - consume and flag in one cycle, produce on length write
// - reset zeros pointers, length write when full and off drains ring
// - empty ring drops packets, descriptors resume
// - receive disable stops writes, no flag; reset
// - station rom image layout
// - control bits seven to four, reset clear
// - after send, flag and wait for disable
// - irq while flags set; status read clears
// - line interface off loops send to receive
module edc_dma #(
  parameter logic [47:0] STATION = 48'h02_00_00_00_00_01,
  parameter logic [15:0] CHKSUM  = 16'h0000
) (
  input  wire logic           sys_clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [7:0]     tx_cmd_i,
  input  wire logic [7:0]     tx_stat_i,
  input  wire logic [7:0]     rx_cmd_i,
  input  wire logic [7:0]     rx_stat_i,
  output edc_pkg::edc_rd_t    tx_rd_o,
  input  wire logic           tx_rd_ready_i,
  input  wire logic [31:0]    tx_rd_data_i,
  output logic                tx_word_valid_o,
  output logic      [31:0]    tx_word_o,
  output logic                tx_first_o,
  input  wire logic           tx_word_ready_i,
  input  wire logic           rx_word_valid_i,
  input  wire logic [31:0]    rx_word_i,
  output logic                rx_word_ready_o,
  input  wire logic           rx_end_i,
  output edc_pkg::edc_wr_t    rx_wr_o,
  input  wire logic           rx_wr_ready_i,
  output logic                loopback_o,
  output logic                word_lane_order_o,
  output logic                irq_o
);
  logic [3:0]  ctrl;
  logic [3:0]  ints;
  logic [7:0]  send_end_status;
  logic [29:0] tx_base;
  logic [15:0] tx_len;
  logic [29:0] rx_base_stage;
  logic [3:0]  descriptor_consume_ptr;
  logic [3:0]  descriptor_produce_ptr;
  logic [41:0] ring_rdata;
  logic [7:0]  rom_byte;
  logic [31:0] next_prdata;
  edc_pkg::edc_tx_st_t tx_st;
  edc_pkg::edc_rx_st_t rx_st;
  logic [29:0] tx_ptr;
  logic [16:0] tx_left;
  logic [29:0] rx_base;
  logic [29:0] rx_ptr;
  logic [11:0] rx_qleft;
  logic [1:0]  rx_wpos;
  logic        rx_ovf;
  logic [1:0]  stat_idx;
  logic [7:0]  receive_end_status;
  logic [31:0] end_word;
  logic        rx_wr_busy;
  logic [31:0] rx_word_i_q;
  logic        rx_flush;
  logic        rom_wait;

  wire send_channel_on    = ctrl[`EDC_CTRL_TXON-4];
  wire receive_channel_on = ctrl[`EDC_CTRL_RXON-4];
  wire line_interface_on  = ctrl[`EDC_CTRL_LINE-4];
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire is_status = paddr == `EDC_OFS_STATUS;
  wire is_peek   = paddr == `EDC_OFS_PEEK;
  wire is_txa    = paddr == `EDC_OFS_TX_ADDR;
  wire is_txl    = paddr == `EDC_OFS_TX_LEN;
  wire is_rxa    = paddr == `EDC_OFS_RX_ADDR;
  wire is_rxl    = paddr == `EDC_OFS_RX_LEN;
  wire is_rom    = paddr[7] && paddr[1:0] == 2'h0;
  wire mapped    = is_status || is_peek || is_txa || is_txl
                   || is_rxa || is_rxl || is_rom;
  wire wr_ok     = access && pwrite && mapped;
  wire ring_empty = descriptor_consume_ptr == descriptor_produce_ptr;
  wire ring_full  = 4'(descriptor_produce_ptr + 4'h1)
                    == descriptor_consume_ptr;
  wire len_wr    = wr_ok && is_rxl;
  wire tx_hit    = |(tx_cmd_i & tx_stat_i);
  wire rx_hit    = |(rx_cmd_i & rx_stat_i);
  wire tx_busy   = tx_st == edc_pkg::TX_READ
                   || tx_st == edc_pkg::TX_PUSH;
  wire tx_end    = tx_busy && tx_hit && send_channel_on;
  wire rx_fin    = rx_st == edc_pkg::RX_STAT && rx_wr_ready_i
                   && stat_idx == `EDC_STAT_COPIES;
  wire status_rd = access && !pwrite && is_status;
  wire rx_take   = rx_word_valid_i && rx_word_ready_o;
  wire rom_stall = access && is_rom && !rom_wait;
  wire [11:0] ring_len  = ring_rdata[11:0];
  wire [29:0] ring_addr = ring_rdata[41:12];

  // rom byte is registered, so a rom access waits one cycle
  assign pready  = !rom_stall;
  assign pslverr = access && !mapped;
  assign word_lane_order_o = ctrl[`EDC_CTRL_ORDER-4];
  assign loopback_o = !line_interface_on;
  assign irq_o = |ints;
  // status word: flag tag, consume ptr, status, quads, bytes
  assign end_word = {`EDC_STAT_TAG, descriptor_consume_ptr,
                     receive_end_status,
                     rx_ovf ? 12'hfff : rx_qleft,
                     rx_wpos, 2'h0};
  assign tx_rd_o.valid = tx_st == edc_pkg::TX_READ
                         && tx_left != 17'h0 && send_channel_on;
  assign tx_rd_o.addr  = tx_ptr;
  // drop words while no buffer is held, stall while writing
  assign rx_word_ready_o = rx_st == edc_pkg::RX_IDLE
                           || (rx_st == edc_pkg::RX_FILL
                               && !rx_wr_busy);
  assign rx_wr_o.valid = rx_wr_busy && receive_channel_on;
  assign rx_wr_o.addr  = rx_ptr;
  assign rx_wr_o.data  = rx_st == edc_pkg::RX_STAT
                         ? end_word : rx_word_i_q;

  edc_ring_mem #(.DEPTH(16), .AW(4), .DW(42)) u_ring (
    .sys_clk_i (sys_clk_i),
    .we_i      (len_wr && !ring_full),
    .waddr_i   (descriptor_produce_ptr),
    .wdata_i   ({rx_base_stage, pwdata[15:4]}),
    .raddr_i   (descriptor_consume_ptr),
    .rdata_o   (ring_rdata)
  );

  edc_station_rom #(.STATION(STATION), .CHKSUM(CHKSUM)) u_rom (
    .sys_clk_i (sys_clk_i),
    .addr_i    (paddr[6:2]),
    .data_o    (rom_byte)
  );

  always_comb begin
    next_prdata = 32'h0;
    if (is_status || is_peek) begin
      next_prdata = {send_end_status, receive_end_status,
                     descriptor_consume_ptr, descriptor_produce_ptr,
                     ctrl, ints};
    end else if (is_txa) begin
      next_prdata = {tx_base, 2'h0};
    end else if (is_txl) begin
      next_prdata = {16'h0, tx_len};
    end else if (is_rxa) begin
      next_prdata = {rx_base_stage, 2'h0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata   <= 32'h0;
      rom_wait <= 1'b0;
    end else begin
      rom_wait <= rom_stall;
      if (setup) begin
        prdata <= next_prdata;
      end else if (access && is_rom) begin
        prdata <= {24'h0, rom_byte};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl          <= `EDC_CTRL_RST;
      tx_base       <= 30'h0;
      tx_len        <= 16'h0;
      rx_base_stage <= 30'h0;
    end else if (wr_ok) begin
      if (is_status) ctrl <= pwdata[7:4];
      if (is_txa) tx_base <= pwdata[31:2];
      if (is_txl) tx_len <= pwdata[15:0];
      if (is_rxa) rx_base_stage <= pwdata[31:2];
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ints <= 4'h0;
    end else begin
      ints[`EDC_INT_TX] <= tx_end
                           || (ints[`EDC_INT_TX] && !status_rd);
      ints[`EDC_INT_RX] <= (rx_fin && receive_channel_on)
                           || (ints[`EDC_INT_RX] && !status_rd);
      ints[1:0] <= 2'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      descriptor_produce_ptr <= 4'h0;
    end else if (len_wr && !ring_full) begin
      descriptor_produce_ptr <= 4'(descriptor_produce_ptr + 4'h1);
    end else if (len_wr && !receive_channel_on) begin
      descriptor_produce_ptr <= descriptor_consume_ptr;
    end
  end

  // send channel
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st           <= edc_pkg::TX_IDLE;
      tx_ptr          <= 30'h0;
      tx_left         <= 17'h0;
      tx_word_valid_o <= 1'b0;
      tx_word_o       <= 32'h0;
      tx_first_o      <= 1'b0;
      send_end_status <= 8'h0;
    end else if (!send_channel_on) begin
      tx_st           <= edc_pkg::TX_IDLE;
      tx_word_valid_o <= 1'b0;
    end else if (tx_end) begin
      tx_st           <= edc_pkg::TX_DONE;
      tx_word_valid_o <= 1'b0;
      send_end_status <= tx_stat_i;
    end else begin
      unique case (tx_st)
        edc_pkg::TX_IDLE: begin
          tx_st      <= edc_pkg::TX_READ;
          tx_ptr     <= tx_base;
          // two skipped bytes, rounded up to words
          tx_left    <= 17'({1'b0, tx_len} + 17'h5) >> 2;
          tx_first_o <= 1'b1;
        end
        edc_pkg::TX_READ: begin
          if (tx_rd_o.valid && tx_rd_ready_i) begin
            tx_st           <= edc_pkg::TX_PUSH;
            tx_word_o       <= tx_rd_data_i;
            tx_word_valid_o <= 1'b1;
            tx_ptr          <= 30'(tx_ptr + 30'h1);
            tx_left         <= 17'(tx_left - 17'h1);
          end
        end
        edc_pkg::TX_PUSH: begin
          if (tx_word_ready_i) begin
            tx_st           <= edc_pkg::TX_READ;
            tx_word_valid_o <= 1'b0;
            tx_first_o      <= 1'b0;
          end
        end
        edc_pkg::TX_DONE: tx_st <= edc_pkg::TX_DONE;
      endcase
    end
  end

  // receive channel
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st                  <= edc_pkg::RX_IDLE;
      rx_base                <= 30'h0;
      rx_ptr                 <= 30'h0;
      rx_qleft               <= 12'h0;
      rx_wpos                <= 2'h0;
      rx_ovf                 <= 1'b0;
      stat_idx               <= 2'h0;
      rx_wr_busy             <= 1'b0;
      rx_word_i_q            <= 32'h0;
      rx_flush               <= 1'b0;
      receive_end_status     <= 8'h0;
      descriptor_consume_ptr <= 4'h0;
    end else if (!receive_channel_on) begin
      rx_st      <= edc_pkg::RX_IDLE;
      rx_wr_busy <= 1'b0;
    end else begin
      unique case (rx_st)
        edc_pkg::RX_IDLE: begin
          if (!ring_empty) rx_st <= edc_pkg::RX_LOAD;
        end
        edc_pkg::RX_LOAD: begin
          rx_st    <= edc_pkg::RX_FILL;
          rx_base  <= ring_addr;
          rx_ptr   <= 30'(ring_addr + `EDC_HDR_WORDS);
          rx_qleft <= 12'(ring_len - 12'h1);
          rx_wpos  <= 2'h0;
          rx_ovf   <= 1'b0;
          rx_flush <= 1'b0;
        end
        edc_pkg::RX_FILL: begin
          // end pulse during a pending write is kept until it is done
          if (rx_end_i) rx_flush <= 1'b1;
          if (rx_wr_busy && rx_wr_ready_i) begin
            rx_wr_busy <= 1'b0;
            rx_ptr     <= 30'(rx_ptr + 30'h1);
          end
          if (rx_hit && !rx_wr_busy) begin
            rx_st              <= edc_pkg::RX_STAT;
            receive_end_status <= rx_stat_i;
            rx_ptr             <= rx_base;
            stat_idx           <= 2'h0;
            rx_wr_busy         <= 1'b1;
          end else if ((rx_end_i || rx_flush) && !rx_wr_busy) begin
            rx_st <= edc_pkg::RX_LOAD;
          end else if (rx_take) begin
            rx_wpos <= 2'(rx_wpos + 2'h1);
            if (rx_wpos == 2'h0 && (rx_ovf || rx_qleft == 12'h0)) begin
              rx_ovf <= 1'b1;
            end else if (!rx_ovf) begin
              if (rx_wpos == 2'h0) rx_qleft <= 12'(rx_qleft - 12'h1);
              rx_word_i_q <= rx_word_i;
              rx_wr_busy  <= 1'b1;
            end
          end
        end
        edc_pkg::RX_STAT: begin
          if (rx_wr_ready_i) begin
            rx_ptr   <= 30'(rx_ptr + 30'h1);
            stat_idx <= 2'(stat_idx + 2'h1);
            if (stat_idx == `EDC_STAT_COPIES) begin
              rx_st      <= edc_pkg::RX_IDLE;
              rx_wr_busy <= 1'b0;
              descriptor_consume_ptr <=
                4'(descriptor_consume_ptr + 4'h1);
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  tx_flag_set_a: assert property (tx_end |=> ints[`EDC_INT_TX])
    else $error("send flag not set on stop");
  tx_off_quiet_a: assert property (!send_channel_on |-> !tx_rd_o.valid)
    else $error("send read while disabled");
  tx_done_hold_a: assert property (tx_st == edc_pkg::TX_DONE
      && send_channel_on |=> tx_st == edc_pkg::TX_DONE)
    else $error("send left done while enabled");
  rx_off_quiet_a: assert property (!receive_channel_on
      |-> !rx_wr_o.valid)
    else $error("receive write while disabled");
  rx_ptr_step_a: assert property (rx_fin && receive_channel_on
      |=> descriptor_consume_ptr
          == 4'($past(descriptor_consume_ptr) + 4'h1)
          && ints[`EDC_INT_RX])
    else $error("consume ptr or flag wrong");
  ring_full_a: assert property (ring_full && len_wr && receive_channel_on
      |=> $stable(descriptor_produce_ptr))
    else $error("produce ptr passed full");
  prod_step_a: assert property (len_wr && !ring_full
      |=> descriptor_produce_ptr
          == 4'($past(descriptor_produce_ptr) + 4'h1))
    else $error("produce ptr not advanced");
  stat_copy_a: assert property (rx_st == edc_pkg::RX_STAT
      && rx_wr_o.valid |-> rx_wr_o.data == end_word
      && rx_wr_o.addr[29:2] == rx_base[29:2])
    else $error("status copy misplaced");
  irq_level_a: assert property (irq_o == (ints != 4'h0))
    else $error("irq does not follow flags");
  loop_sel_a: assert property (loopback_o == !line_interface_on)
    else $error("loopback select wrong");
  clr_read_a: assert property (status_rd && !tx_end
      |=> !ints[`EDC_INT_TX])
    else $error("status read did not clear");

  tx_done_c: cover property (tx_end);
  rx_done_c: cover property (rx_fin);
  rx_ovf_c: cover property (rx_ovf && rx_hit);
  ring_full_c: cover property (ring_full);
endmodule // edc_dma

// ### verif/edc_far_model.sv
// far-side model: memory for both channels and the controller's
// word handshakes; answers every other cycle, slower when slow_i
`timescale 1ns/1ps
module edc_far_model (
  input  wire logic             sys_clk_i,
  input  wire logic             slow_i,
  input  wire edc_pkg::edc_rd_t tx_rd_i,
  output logic                  tx_rd_ready_o,
  output logic      [31:0]      tx_rd_data_o,
  input  wire logic             tx_word_valid_i,
  input  wire logic [31:0]      tx_word_i,
  input  wire logic             tx_first_i,
  output logic                  tx_word_ready_o,
  input  wire edc_pkg::edc_wr_t rx_wr_i,
  output logic                  rx_wr_ready_o
);
  logic [31:0] mem [0:1023];
  logic [31:0] first_word;
  logic [2:0]  cnt = 3'h0;
  logic        go;
  int          sent_cnt = 0;
  int          wr_cnt = 0;
  initial begin
    tx_rd_ready_o = 1'b0;
    tx_word_ready_o = 1'b0;
    rx_wr_ready_o = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'ha5a5_0000 + 32'(i);
    end
  end
  assign go = !slow_i || cnt[2];
  // read data shows the inverse until ready is given, never a stale match
  assign tx_rd_data_o = tx_rd_ready_o ? mem[tx_rd_i.addr[9:0]]
                                      : ~mem[tx_rd_i.addr[9:0]];
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 3'h1;
    tx_rd_ready_o <= tx_rd_i.valid && !tx_rd_ready_o && go;
    tx_word_ready_o <= tx_word_valid_i && !tx_word_ready_o && go;
    rx_wr_ready_o <= rx_wr_i.valid && !rx_wr_ready_o && go;
    if (tx_word_valid_i && tx_word_ready_o) begin
      sent_cnt <= sent_cnt + 1;
      if (tx_first_i) begin
        first_word <= tx_word_i;
      end
    end
    if (rx_wr_i.valid && rx_wr_ready_o) begin
      mem[rx_wr_i.addr[9:0]] <= rx_wr_i.data;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule // edc_far_model

// ### verif/edc_dma_bench.sv
// self-checking bench for the dma channels
// assumes edc_dma as apb slave and edc_far_model on the far side
`timescale 1ns/1ps
module edc_dma_bench;
  logic             sys_clk_i;
  logic             rst_n_i = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [7:0]       tx_cmd = 8'h00;
  logic [7:0]       tx_stat = 8'h00;
  logic [7:0]       rx_cmd = 8'h00;
  logic [7:0]       rx_stat = 8'h00;
  edc_pkg::edc_rd_t tx_rd;
  logic             tx_rd_rdy;
  logic [31:0]      tx_rd_data;
  logic             tw_valid;
  logic [31:0]      tw_data;
  logic             tw_first;
  logic             tw_rdy;
  logic             rw_valid = 1'b0;
  logic [31:0]      rw_data = 32'h0;
  logic             rw_rdy;
  logic             rx_end = 1'b0;
  edc_pkg::edc_wr_t rx_wr;
  logic             rx_wr_rdy;
  logic             loopback;
  logic             lane_order;
  logic             irq;
  logic             slow = 1'b0;
  logic [31:0]      rdata;
  logic             perr;
  logic [7:0]       pat [4] = '{8'hff, 8'h00, 8'h55, 8'haa};
  int               error_cnt = 0;
  int               num_checks = 0;
  int               base;
  int               n;

  edc_dma u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_cmd_i(tx_cmd), .tx_stat_i(tx_stat),
    .rx_cmd_i(rx_cmd), .rx_stat_i(rx_stat), .tx_rd_o(tx_rd),
    .tx_rd_ready_i(tx_rd_rdy), .tx_rd_data_i(tx_rd_data),
    .tx_word_valid_o(tw_valid), .tx_word_o(tw_data),
    .tx_first_o(tw_first), .tx_word_ready_i(tw_rdy),
    .rx_word_valid_i(rw_valid), .rx_word_i(rw_data),
    .rx_word_ready_o(rw_rdy), .rx_end_i(rx_end), .rx_wr_o(rx_wr),
    .rx_wr_ready_i(rx_wr_rdy), .loopback_o(loopback),
    .word_lane_order_o(lane_order), .irq_o(irq)
  );

  edc_far_model u_far (
    .sys_clk_i(sys_clk_i), .slow_i(slow), .tx_rd_i(tx_rd),
    .tx_rd_ready_o(tx_rd_rdy), .tx_rd_data_o(tx_rd_data),
    .tx_word_valid_i(tw_valid), .tx_word_i(tw_data),
    .tx_first_i(tw_first), .tx_word_ready_o(tw_rdy),
    .rx_wr_i(rx_wr), .rx_wr_ready_o(rx_wr_rdy)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("[ERR] %0t timeout: %s", $time, what);
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) hang("apb");
  endtask

  task automatic send_rx(input logic [31:0] w);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    rw_valid <= 1'b1;
    rw_data <= w;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (rw_rdy !== 1'b1 && k < 100);
    rw_valid <= 1'b0;
    rw_data <= ~w;
    if (k >= 100) hang("rx word");
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 400) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= 400) hang("interrupt");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata, 32'h0);
    chk(32'(loopback), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h00, 32'h0000_00c0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'h0000_00f0, 32'h0000_00c0);
    chk({30'h0, lane_order, loopback}, 32'h2);
    for (int k = 24; k < 32; k++) begin
      apb(1'b0, 8'h80 + 8'(4 * k), 32'h0);
      chk(rdata, {24'h0, pat[k % 4]});
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // send: command, buffer, then enable; slow memory
    tx_cmd <= 8'h0d;
    slow <= 1'b1;
    apb(1'b1, 8'h08, 32'h0000_0103);
    apb(1'b1, 8'h0c, 32'h0001_0008);
    base = u_far.sent_cnt;
    apb(1'b1, 8'h00, 32'h0000_0060);
    n = 0;
    while (u_far.sent_cnt - base < 3 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 400) hang("send words");
    chk(u_far.first_word, 32'ha5a5_0040);
    tx_stat <= 8'h01;
    wait_irq();
    repeat (5) @(posedge sys_clk_i);
    chk(32'(u_far.sent_cnt - base), 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'hff00_000c, 32'h0100_0008);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata & 32'h0000_0008, 32'h0000_0008);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'h0000_0008, 32'h0);
    chk(32'(irq), 32'h0);
    // send stopped early by clearing enable
    apb(1'b1, 8'h00, 32'h0000_0040);
    tx_stat <= 8'h00;
    apb(1'b1, 8'h08, 32'h0000_0100);
    apb(1'b1, 8'h0c, 32'h0000_0040);
    base = u_far.sent_cnt;
    apb(1'b1, 8'h00, 32'h0000_0060);
    apb(1'b1, 8'h00, 32'h0000_0040);
    tx_stat <= 8'h01;
    repeat (20) @(posedge sys_clk_i);
    chk(32'(irq), 32'h0);
    chk(32'(u_far.sent_cnt - base < 17), 32'h1);
    tx_stat <= 8'h00;
    // receive: flushed packet, then a good one into the same buffer
    slow <= 1'b0;
    rx_cmd <= 8'ha0;
    apb(1'b1, 8'h10, 32'h0000_0203);
    apb(1'b1, 8'h14, 32'h0000_004f);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'h0000_ff00, 32'h0000_0100);
    apb(1'b1, 8'h00, 32'h0000_0050);
    send_rx(32'h1111_1111);
    @(posedge sys_clk_i);
    rx_end <= 1'b1;
    @(posedge sys_clk_i);
    rx_end <= 1'b0;
    for (int k = 2; k < 5; k++) send_rx(32'h1111_1111 * k);
    rx_stat <= 8'h80;
    wait_irq();
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata & 32'h00ff_ffff, 32'h0080_1154);
    rx_stat <= 8'h00;
    for (int k = 0; k < 4; k++) begin
      chk(u_far.mem[32'h80 + k] & 32'hf0ff_ffff, 32'h0080_002c);
    end
    for (int k = 2; k < 5; k++) begin
      chk(u_far.mem[32'h82 + k], 32'h1111_1111 * k);
    end
    // empty ring drops, a new descriptor resumes, then overflow
    base = u_far.wr_cnt;
    send_rx(32'h5555_5555);
    repeat (8) @(posedge sys_clk_i);
    chk(32'(u_far.wr_cnt - base), 32'h0);
    apb(1'b1, 8'h10, 32'h0000_0400);
    apb(1'b1, 8'h14, 32'h0000_0020);
    for (int k = 0; k < 6; k++) send_rx(32'h0000_0066);
    rx_cmd <= 8'ha1;
    rx_stat <= 8'h01;
    wait_irq();
    rx_stat <= 8'h00;
    chk(u_far.mem[32'h100] & 32'hf0ff_fff0, 32'h0001_fff0);
    chk(u_far.mem[32'h108], 32'ha5a5_0108);
    // ring fills at fifteen, a further write while off empties it
    apb(1'b1, 8'h00, 32'h0000_0040);
    for (int k = 0; k < 15; k++) apb(1'b1, 8'h14, 32'h0000_0010);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'h0000_ff00, 32'h0000_2100);
    apb(1'b1, 8'h14, 32'h0000_0010);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdata & 32'h0000_ff00, 32'h0000_2200);
    print_verdict();
  end
endmodule // edc_dma_bench
